// file: design/tss_map.svh
// Register offsets, field positions, reset values and source codes for start-up clock select
`ifndef TSS_MAP_SVH
`define TSS_MAP_SVH
`define TSS_OFS_CTL 12'h000
`define TSS_OFS_DIV 12'h004
`define TSS_OFS_FBD 12'h008
`define TSS_OFS_TUN 12'h00c
`define TSS_OFS_SEL 12'h010
`define TSS_OFS_CFG 12'h014
`define TSS_ADDR_BITS 11:0
`define TSS_RST_CTL 16'h7700
`define TSS_RST_DIV 16'h0000
`define TSS_RST_FBD 9'h030
`define TSS_RST_TUN 6'h00
`define TSS_CTL_CURRENT_SOURCE_SEL 14:12
`define TSS_CTL_REQUESTED_SOURCE_SEL 10:8
`define TSS_CTL_FREEZE 7
`define TSS_CTL_REMAP 6
`define TSS_CTL_LOCK 5
`define TSS_CTL_CF 3
`define TSS_CTL_SOSC 1
`define TSS_CTL_SWITCH_REQUEST_BIT 0
`define TSS_DIV_MASK 16'hffdf
`define TSS_FBD_BITS 8:0
`define TSS_TUN_BITS 5:0
`define TSS_SEL_TWO_SPEED_STARTUP_ENABLE 7
`define TSS_SEL_RSV 5
`define TSS_SEL_INITIAL_SOURCE_FIELD 2:0
`define TSS_CFG_CKSM 7:6
`define TSS_CFG_ONESHOT 5
`define TSS_CFG_PINFN 2
`define TSS_CFG_PRIMARY_OSC_MODE 1:0
`define TSS_SRC_FRC 3'h0
`define TSS_SRC_FRCPLL 3'h1
`define TSS_SRC_PRI 3'h2
`define TSS_SRC_PRIPLL 3'h3
`define TSS_SRC_SEC 3'h4
`define TSS_SRC_FRC16 3'h6
`define TSS_SRC_FAST_RC_POSTSCALER 3'h7
`define TSS_CKSM_CLOCK_FAIL_MONITOR 2'h0
`define TSS_CKSM_SWONLY 2'h1
`define TSS_SYNC_LAT 2'h2
`endif

// file: design/tss_pkg.sv
// Types for start-up clock select
package tss_pkg;
  typedef enum logic [1:0] {
    TSS_CAP = 2'h0,
    TSS_WAIT = 2'h1,
    TSS_RUN = 2'h3
  } tss_state_t;
endpackage

// file: design/tss_sync.sv
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/10ps
module tss_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tss_sync_st_t;
  tss_sync_st_t s;
  tss_sync_st_t next_s;

  always_comb begin
    next_s = s;
    if (ce) begin
      next_s.s1 = d;
      next_s.s2 = s.s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.s2;
endmodule

// file: design/tss_top.sv
// Start-up clock source selection with APB register file
`timescale 1ns/10ps
`include "tss_map.svh"
module tss_top #(
  parameter bit HAS_PIN_REMAP = 1'b1
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration words
  input wire logic [15:0] cfg_source_select,
  input wire logic [15:0] cfg_osc_config,
  // Oscillator status
  input wire logic prim_osc_stable,
  input wire logic sec_osc_stable,
  input wire logic pll_locked,
  input wire logic clock_fail_det,
  // Clock control
  output logic [2:0] core_clk_sel,
  output logic frc_osc_enable,
  output logic sec_osc_enable
);
  typedef struct packed {
    tss_pkg::tss_state_t st;
    logic [1:0] cnt;
    logic [2:0] cur;
    logic [2:0] req;
    logic freeze;
    logic remap_freeze;
    logic lock;
    logic cf;
    logic sosc_en;
    logic switch_request_bit;
    logic [15:0] clock_divider_control;
    logic [8:0] pll_feedback_divisor;
    logic [5:0] fast_rc_trim;
    logic two_speed_startup_enable;
    logic sel_rsv;
    logic [2:0] initial_source_field;
    logic [1:0] cksm;
    logic one_shot;
    logic pinfn;
    logic [1:0] primary_osc_mode;
    logic [2:0] clk_sel;
    logic frc_en;
    logic sec_en;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } tss_top_st_t;

  tss_top_st_t s;
  tss_top_st_t next_s;

  logic [35:0] sync_q;
  logic prim_s;
  logic sec_s;
  logic lock_s;
  logic fail_s;
  logic [15:0] sel_s;
  logic [15:0] cfg_s;

  // Status pins and straps arrive asynchronously
  tss_sync #(.W(36)) i_tss_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d({prim_osc_stable, sec_osc_stable, pll_locked, clock_fail_det,
        cfg_source_select, cfg_osc_config}),
    .q(sync_q)
  );

  assign prim_s = sync_q[35];
  assign sec_s = sync_q[34];
  assign lock_s = sync_q[33];
  assign fail_s = sync_q[32];
  assign sel_s = sync_q[31:16];
  assign cfg_s = sync_q[15:0];

  function automatic logic frc_based(input logic [2:0] src);
    frc_based = (src == `TSS_SRC_FRC) || (src == `TSS_SRC_FRCPLL) ||
                (src == `TSS_SRC_FRC16) || (src == `TSS_SRC_FAST_RC_POSTSCALER);
  endfunction

  // Crystal sources need stable oscillation; PLL sources need lock as well
  function automatic logic src_ready(input logic [2:0] src, input logic pri,
                                     input logic sec, input logic lk);
    case (src)
      `TSS_SRC_FRCPLL: src_ready = lk;
      `TSS_SRC_PRI: src_ready = pri;
      `TSS_SRC_PRIPLL: src_ready = pri && lk;
      `TSS_SRC_SEC: src_ready = sec;
      default: src_ready = 1'b1;
    endcase
  endfunction

  logic access;
  logic wr_done;
  logic [11:0] addr;
  logic ctl_wr;
  logic clock_fail_monitor_on;
  logic rdy;
  logic sw_allowed;
  logic [15:0] ctl_rd;
  logic [15:0] rd_word;
  logic rd_hit;

  assign access = psel && penable;
  assign wr_done = access && s.pready && pwrite;
  assign addr = paddr[`TSS_ADDR_BITS];
  assign ctl_wr = wr_done && (addr == `TSS_OFS_CTL);
  assign clock_fail_monitor_on = (s.cksm == `TSS_CKSM_CLOCK_FAIL_MONITOR);
  assign rdy = src_ready(s.req, prim_s, sec_s, lock_s);
  // Freeze bit only blocks switching when monitor is off and switching on
  assign sw_allowed = !s.cksm[1] && !(s.freeze && (s.cksm == `TSS_CKSM_SWONLY));

  always_comb begin
    ctl_rd = 16'h0000;
    ctl_rd[`TSS_CTL_CURRENT_SOURCE_SEL] = s.cur;
    ctl_rd[`TSS_CTL_REQUESTED_SOURCE_SEL] = s.req;
    ctl_rd[`TSS_CTL_FREEZE] = s.freeze;
    ctl_rd[`TSS_CTL_REMAP] = s.remap_freeze && HAS_PIN_REMAP;
    ctl_rd[`TSS_CTL_LOCK] = s.lock;
    ctl_rd[`TSS_CTL_CF] = s.cf;
    ctl_rd[`TSS_CTL_SOSC] = s.sosc_en;
    ctl_rd[`TSS_CTL_SWITCH_REQUEST_BIT] = s.switch_request_bit;
  end

  always_comb begin
    rd_word = 16'h0000;
    rd_hit = 1'b1;
    case (addr)
      `TSS_OFS_CTL: rd_word = ctl_rd;
      `TSS_OFS_DIV: rd_word = s.clock_divider_control & `TSS_DIV_MASK;
      `TSS_OFS_FBD: rd_word[`TSS_FBD_BITS] = s.pll_feedback_divisor;
      `TSS_OFS_TUN: rd_word[`TSS_TUN_BITS] = s.fast_rc_trim;
      `TSS_OFS_SEL: begin
        rd_word[`TSS_SEL_TWO_SPEED_STARTUP_ENABLE] = s.two_speed_startup_enable;
        rd_word[`TSS_SEL_RSV] = s.sel_rsv;
        rd_word[`TSS_SEL_INITIAL_SOURCE_FIELD] = s.initial_source_field;
      end
      `TSS_OFS_CFG: begin
        rd_word[`TSS_CFG_CKSM] = s.cksm;
        rd_word[`TSS_CFG_ONESHOT] = s.one_shot && HAS_PIN_REMAP;
        rd_word[`TSS_CFG_PINFN] = s.pinfn;
        rd_word[`TSS_CFG_PRIMARY_OSC_MODE] = s.primary_osc_mode;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    next_s = s;
    if (ce) begin
      // One wait state: answer registered in the first access cycle
      next_s.pready = access && !s.pready;
      if (access && !s.pready) begin
        next_s.prdata = {16'h0000, rd_word};
        next_s.pslverr = !rd_hit;
      end
      next_s.lock = lock_s;
      // A failure seen in the clearing cycle still sets the flag
      next_s.cf = (s.cf && !(ctl_wr && !pwdata[`TSS_CTL_CF])) || fail_s;
      if (ctl_wr) begin
        next_s.req = pwdata[`TSS_CTL_REQUESTED_SOURCE_SEL];
        next_s.freeze = s.freeze || pwdata[`TSS_CTL_FREEZE];
        next_s.remap_freeze = HAS_PIN_REMAP && (s.remap_freeze || pwdata[`TSS_CTL_REMAP]);
        next_s.sosc_en = pwdata[`TSS_CTL_SOSC];
      end
      if (wr_done && (addr == `TSS_OFS_DIV)) begin
        next_s.clock_divider_control = pwdata[15:0] & `TSS_DIV_MASK;
      end
      if (wr_done && (addr == `TSS_OFS_FBD)) begin
        next_s.pll_feedback_divisor = pwdata[`TSS_FBD_BITS];
      end
      if (wr_done && (addr == `TSS_OFS_TUN)) begin
        next_s.fast_rc_trim = pwdata[`TSS_TUN_BITS];
      end
      case (s.st)
        tss_pkg::TSS_CAP: begin
          // Straps need the synchroniser latency before they are valid
          if (s.cnt != `TSS_SYNC_LAT) begin
            next_s.cnt = s.cnt + 2'h1;
          end else begin
            next_s.two_speed_startup_enable = sel_s[`TSS_SEL_TWO_SPEED_STARTUP_ENABLE];
            next_s.sel_rsv = sel_s[`TSS_SEL_RSV];
            next_s.initial_source_field = sel_s[`TSS_SEL_INITIAL_SOURCE_FIELD];
            next_s.cksm = cfg_s[`TSS_CFG_CKSM];
            next_s.one_shot = HAS_PIN_REMAP && cfg_s[`TSS_CFG_ONESHOT];
            next_s.pinfn = cfg_s[`TSS_CFG_PINFN];
            next_s.primary_osc_mode = cfg_s[`TSS_CFG_PRIMARY_OSC_MODE];
            next_s.req = sel_s[`TSS_SEL_INITIAL_SOURCE_FIELD];
            if (sel_s[`TSS_SEL_TWO_SPEED_STARTUP_ENABLE] && (sel_s[`TSS_SEL_INITIAL_SOURCE_FIELD] != `TSS_SRC_FRC)) begin
              next_s.cur = `TSS_SRC_FRC;
              next_s.switch_request_bit = 1'b1;
              next_s.st = tss_pkg::TSS_WAIT;
            end else begin
              next_s.cur = sel_s[`TSS_SEL_INITIAL_SOURCE_FIELD];
              next_s.switch_request_bit = 1'b0;
              next_s.st = tss_pkg::TSS_RUN;
            end
          end
        end
        tss_pkg::TSS_WAIT: begin
          if (ctl_wr && !pwdata[`TSS_CTL_SWITCH_REQUEST_BIT]) begin
            // Abort keeps the old clock
            next_s.switch_request_bit = 1'b0;
            next_s.req = s.cur;
            next_s.st = tss_pkg::TSS_RUN;
          end else if (rdy) begin
            // No switching-mode check here, so start-up completes in every mode once the source is ready
            next_s.cur = s.req;
            next_s.switch_request_bit = 1'b0;
            next_s.st = tss_pkg::TSS_RUN;
          end
        end
        tss_pkg::TSS_RUN: begin
          if (ctl_wr && pwdata[`TSS_CTL_SWITCH_REQUEST_BIT] && sw_allowed &&
              (pwdata[`TSS_CTL_REQUESTED_SOURCE_SEL] != s.cur)) begin
            next_s.switch_request_bit = 1'b1;
            next_s.st = tss_pkg::TSS_WAIT;
          end
        end
        default: begin
          next_s.st = tss_pkg::TSS_CAP;
          next_s.cnt = 2'h0;
        end
      endcase
      if (next_s.st != tss_pkg::TSS_CAP) begin
        next_s.clk_sel = next_s.cur;
        next_s.frc_en = frc_based(next_s.cur) || (next_s.cksm == `TSS_CKSM_CLOCK_FAIL_MONITOR);
        next_s.sec_en = next_s.sosc_en || (next_s.cur == `TSS_SRC_SEC) ||
                        (next_s.req == `TSS_SRC_SEC);
      end
    end
  end

  // Source fields are cut from the reset word, so only constants reach the reset branch
  localparam logic [15:0] CTL_RESET = `TSS_RST_CTL;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= tss_pkg::TSS_CAP;
      s.cur <= CTL_RESET[`TSS_CTL_CURRENT_SOURCE_SEL];
      s.req <= CTL_RESET[`TSS_CTL_REQUESTED_SOURCE_SEL];
      s.clock_divider_control <= `TSS_RST_DIV;
      s.pll_feedback_divisor <= `TSS_RST_FBD;
      s.fast_rc_trim <= `TSS_RST_TUN;
      s.clk_sel <= `TSS_SRC_FRC;
      s.frc_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign core_clk_sel = s.clk_sel;
  assign frc_osc_enable = s.frc_en;
  assign sec_osc_enable = s.sec_en;

  logic cap_now;
  assign cap_now = ce && (s.st == tss_pkg::TSS_CAP) && (s.cnt == `TSS_SYNC_LAT);

  property p_two_speed_startup_enable_frc;
    @(posedge pclk) disable iff (!presetn)
    cap_now && sel_s[`TSS_SEL_TWO_SPEED_STARTUP_ENABLE] && (sel_s[`TSS_SEL_INITIAL_SOURCE_FIELD] != `TSS_SRC_FRC)
      |=> (core_clk_sel == `TSS_SRC_FRC) && frc_osc_enable && (s.st == tss_pkg::TSS_WAIT);
  endproperty
  a_two_speed_startup_enable_frc: assert property (p_two_speed_startup_enable_frc) else $error("start-up not on fast RC");

  property p_direct;
    @(posedge pclk) disable iff (!presetn)
    cap_now && !sel_s[`TSS_SEL_TWO_SPEED_STARTUP_ENABLE]
      |=> (core_clk_sel == $past(sel_s[`TSS_SEL_INITIAL_SOURCE_FIELD])) && (s.cur == s.req);
  endproperty
  a_direct: assert property (p_direct) else $error("direct start source wrong");

  property p_auto_switch;
    @(posedge pclk) disable iff (!presetn)
    ce && (s.st == tss_pkg::TSS_WAIT) && rdy && !ctl_wr
      |=> (s.cur == $past(s.req)) && !s.switch_request_bit && (core_clk_sel == s.cur);
  endproperty
  a_auto_switch: assert property (p_auto_switch) else $error("switch missed");

  property p_hold_frc;
    @(posedge pclk) disable iff (!presetn)
    ce && (s.st == tss_pkg::TSS_WAIT) && !rdy && !ctl_wr
      |=> (core_clk_sel == $past(core_clk_sel)) && (s.cur != s.req) && s.switch_request_bit;
  endproperty
  a_hold_frc: assert property (p_hold_frc) else $error("left fast RC early");

  property p_frc_off;
    @(posedge pclk) disable iff (!presetn)
    (s.st == tss_pkg::TSS_RUN) && !frc_based(s.cur) && (s.cksm != `TSS_CKSM_CLOCK_FAIL_MONITOR)
      |-> !frc_osc_enable;
  endproperty
  a_frc_off: assert property (p_frc_off) else $error("fast RC left running");

  property p_clock_fail_monitor_keep;
    @(posedge pclk) disable iff (!presetn)
    (s.st != tss_pkg::TSS_CAP) && (s.cksm == `TSS_CKSM_CLOCK_FAIL_MONITOR) |-> frc_osc_enable;
  endproperty
  a_clock_fail_monitor_keep: assert property (p_clock_fail_monitor_keep) else $error("fast RC off with monitor");

  property p_no_switch_frc;
    @(posedge pclk) disable iff (!presetn)
    cap_now && (sel_s[`TSS_SEL_INITIAL_SOURCE_FIELD] == `TSS_SRC_FRC)
      |=> (s.st == tss_pkg::TSS_RUN) ##1 (core_clk_sel == `TSS_SRC_FRC);
  endproperty
  a_no_switch_frc: assert property (p_no_switch_frc) else $error("needless switch");

  property p_done_copy;
    @(posedge pclk) disable iff (!presetn)
    ($past(s.st) == tss_pkg::TSS_WAIT) && (s.st == tss_pkg::TSS_RUN) && $past(rdy)
      && !$past(ctl_wr) |-> (s.cur == s.req) && !s.switch_request_bit;
  endproperty
  a_done_copy: assert property (p_done_copy) else $error("completion fields wrong");

  property p_rd_zero;
    @(posedge pclk) disable iff (!presetn)
    pready && !pwrite && (paddr[`TSS_ADDR_BITS] == `TSS_OFS_FBD)
      |-> (prdata[31:9] == 23'h000000);
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unimplemented bits set");

  property p_cf_sticky;
    @(posedge pclk) disable iff (!presetn)
    ce && fail_s |=> s.cf;
  endproperty
  a_cf_sticky: assert property (p_cf_sticky) else $error("clock-fail event lost");

  // Locked selection must refuse a software switch in the switching-only mode
  property p_freeze_block;
    @(posedge pclk) disable iff (!presetn)
    ce && ctl_wr && (s.st == tss_pkg::TSS_RUN) && s.freeze && (s.cksm == `TSS_CKSM_SWONLY)
      |=> (s.st == tss_pkg::TSS_RUN) && !s.switch_request_bit;
  endproperty
  a_freeze_block: assert property (p_freeze_block) else $error("locked switch taken");

  c_two_speed: cover property (@(posedge pclk) disable iff (!presetn)
    (s.st == tss_pkg::TSS_WAIT) && s.two_speed_startup_enable ##1 (s.st == tss_pkg::TSS_RUN));
  c_direct: cover property (@(posedge pclk) disable iff (!presetn)
    cap_now && !sel_s[`TSS_SEL_TWO_SPEED_STARTUP_ENABLE]);
  c_sw_switch: cover property (@(posedge pclk) disable iff (!presetn)
    (s.st == tss_pkg::TSS_RUN) && ctl_wr ##1 (s.st == tss_pkg::TSS_WAIT));
endmodule

// file: test/tss_osc_model.sv
// Oscillator sources model: stability and PLL lock after programmable delays
`timescale 1ns/10ps
module tss_osc_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Secondary enable and start-up delays in cycles, zero means never ready
  input wire logic sec_en,
  input wire logic [15:0] prim_dly,
  input wire logic [15:0] sec_dly,
  input wire logic [15:0] lock_dly,
  // Status towards the block
  output logic prim_osc_stable,
  output logic sec_osc_stable,
  output logic pll_locked
);
  logic [15:0] t_on;
  logic [15:0] t_sec;

  // Secondary only counts while enabled, so a late enable delays readiness
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_on <= 16'h0000;
      t_sec <= 16'h0000;
    end else begin
      if (t_on != 16'hffff) t_on <= t_on + 16'h0001;
      if (!sec_en) t_sec <= 16'h0000;
      else if (t_sec != 16'hffff) t_sec <= t_sec + 16'h0001;
    end
  end

  // Oscillation start and start-up timer folded into one delay
  assign prim_osc_stable = (prim_dly != 16'h0000) && (t_on >= prim_dly);
  assign sec_osc_stable = sec_en && (sec_dly != 16'h0000) && (t_sec >= sec_dly);
  assign pll_locked = (lock_dly != 16'h0000) && (t_on >= lock_dly);
endmodule

// file: test/two_speed_startup_clock_select_bench.sv
// Self-checking bench for start-up clock select
`timescale 1ns/10ps
`include "tss_map.svh"
module two_speed_startup_clock_select_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] cfg_source_select = 16'h0;
  logic [15:0] cfg_osc_config = 16'h0;
  logic clock_fail_det = 1'b0;
  logic [15:0] prim_dly = 16'h0;
  logic [15:0] sec_dly = 16'h0;
  logic [15:0] lock_dly = 16'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic prim_osc_stable;
  logic sec_osc_stable;
  logic pll_locked;
  logic [2:0] core_clk_sel;
  logic frc_osc_enable;
  logic sec_osc_enable;
  int fail_count = 0;
  int tests_run = 0;
  logic [11:0] ofs [3] = '{12'h004, 12'h008, 12'h00c};
  logic [31:0] rst [3] = '{32'h0, 32'h30, 32'h0};
  logic [31:0] msk [3] = '{32'hffdf, 32'h01ff, 32'h003f};

  always #4 pclk = ~pclk;

  tss_top i_tss_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_source_select(cfg_source_select), .cfg_osc_config(cfg_osc_config),
    .prim_osc_stable(prim_osc_stable), .sec_osc_stable(sec_osc_stable),
    .pll_locked(pll_locked), .clock_fail_det(clock_fail_det),
    .core_clk_sel(core_clk_sel), .frc_osc_enable(frc_osc_enable),
    .sec_osc_enable(sec_osc_enable));

  tss_osc_model i_tss_osc_model (.pclk(pclk), .presetn(presetn), .sec_en(sec_osc_enable),
    .prim_dly(prim_dly), .sec_dly(sec_dly), .lock_dly(lock_dly),
    .prim_osc_stable(prim_osc_stable), .sec_osc_stable(sec_osc_stable),
    .pll_locked(pll_locked));

  task finish_test;
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One transfer; answer taken at the rising edge that sees pready high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {20'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    while (!rdy && n < 50) begin
      @(posedge pclk);
      rdy = (pready === 1'b1);
      n++;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!rdy) begin
      fail_count++;
      $display("[ERR] %0t bus transfer not answered", $time);
      finish_test;
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp, "read data");
    chk({31'h0, e}, {31'h0, exp_err}, "error response");
  endtask

  function automatic logic [31:0] ctl(input logic [2:0] cur, input logic [2:0] req,
                                      input logic lk, input logic cf, input logic osw);
    return {16'h0, 1'b0, cur, 1'b0, req, 2'b00, lk, 1'b0, cf, 2'b00, osw};
  endfunction

  // Configuration words are straps, so each one needs its own power-on
  task boot(input logic [15:0] sel, input logic [15:0] cfg, input logic [15:0] pd,
            input logic [15:0] sd, input logic [15:0] ld);
    @(posedge pclk);
    presetn <= 1'b0;
    cfg_source_select <= sel;
    cfg_osc_config <= cfg;
    prim_dly <= pd;
    sec_dly <= sd;
    lock_dly <= ld;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  task wait_sel(input logic [2:0] exp, input int bound);
    int n;
    n = 0;
    while (core_clk_sel !== exp && n < bound) begin
      @(negedge pclk);
      n++;
    end
    if (core_clk_sel !== exp) begin
      fail_count++;
      $display("[ERR] %0t core clock never reached %0d", $time, exp);
      finish_test;
    end
  endtask

  initial begin
    // Reserved bit 5 always programmed high; bits 6,4,3 set to probe unused positions
    boot(16'h00fa, 16'h0059, 16'd60, 16'd0, 16'd0);
    chk({29'h0, core_clk_sel}, 32'h0, "core on fast RC");
    chk({31'h0, frc_osc_enable}, 32'h1, "fast RC running");
    rd_chk(`TSS_OFS_CTL, ctl(3'h0, 3'h2, 1'b0, 1'b0, 1'b1), 1'b0);
    rd_chk(`TSS_OFS_SEL, 32'h00a2, 1'b0);
    rd_chk(`TSS_OFS_CFG, 32'h0041, 1'b0);
    wait_sel(3'h2, 80);
    chk({31'h0, frc_osc_enable}, 32'h0, "fast RC stopped");
    rd_chk(`TSS_OFS_CTL, ctl(3'h2, 3'h2, 1'b0, 1'b0, 1'b0), 1'b0);
    for (int i = 0; i < 3; i++) begin
      rd_chk(ofs[i], rst[i], 1'b0);
      wr(ofs[i], 32'hffffffff);
      rd_chk(ofs[i], msk[i], 1'b0);
    end
    wr(`TSS_OFS_SEL, 32'h0000ffff);
    rd_chk(`TSS_OFS_SEL, 32'h00a2, 1'b0);
    rd_chk(12'h018, 32'h0, 1'b1);
    @(posedge pclk);
    clock_fail_det <= 1'b1;
    @(posedge pclk);
    clock_fail_det <= 1'b0;
    repeat (4) @(posedge pclk);
    rd_chk(`TSS_OFS_CTL, ctl(3'h2, 3'h2, 1'b0, 1'b1, 1'b0), 1'b0);
    wr(`TSS_OFS_CTL, ctl(3'h2, 3'h2, 1'b0, 1'b0, 1'b0));
    rd_chk(`TSS_OFS_CTL, ctl(3'h2, 3'h2, 1'b0, 1'b0, 1'b0), 1'b0);

    // Primary stable early, lock late, monitor enabled
    boot(16'h00a3, 16'h0001, 16'd10, 16'd0, 16'd70);
    repeat (40) @(posedge pclk);
    chk({29'h0, core_clk_sel}, 32'h0, "waiting for lock");
    ce <= 1'b0;
    repeat (40) @(posedge pclk);
    chk({29'h0, core_clk_sel}, 32'h0, "frozen while disabled");
    ce <= 1'b1;
    wait_sel(3'h3, 80);
    chk({31'h0, frc_osc_enable}, 32'h1, "fast RC kept for monitor");
    rd_chk(`TSS_OFS_CTL, ctl(3'h3, 3'h3, 1'b1, 1'b0, 1'b0), 1'b0);

    // Runtime switching disabled in the mode field
    boot(16'h00a2, 16'h0081, 16'd20, 16'd0, 16'd0);
    wait_sel(3'h2, 60);
    chk({31'h0, frc_osc_enable}, 32'h0, "fast RC stopped");

    // Secondary source, enabled by the block itself
    boot(16'h00a4, 16'h0041, 16'd0, 16'd30, 16'd0);
    chk({31'h0, sec_osc_enable}, 32'h1, "secondary enabled");
    wait_sel(3'h4, 80);

    // Start-up option clear: no fast RC phase even with an unready source
    boot(16'h0022, 16'h0041, 16'd0, 16'd0, 16'd0);
    chk({29'h0, core_clk_sel}, 32'h2, "direct start");
    rd_chk(`TSS_OFS_CTL, ctl(3'h2, 3'h2, 1'b0, 1'b0, 1'b0), 1'b0);

    // Configured source is fast RC itself
    boot(16'h00a0, 16'h0041, 16'd5, 16'd0, 16'd0);
    repeat (20) @(posedge pclk);
    chk({29'h0, core_clk_sel}, 32'h0, "stays on fast RC");
    chk({31'h0, frc_osc_enable}, 32'h1, "fast RC running");
    rd_chk(`TSS_OFS_CTL, ctl(3'h0, 3'h0, 1'b0, 1'b0, 1'b0), 1'b0);
    wr(`TSS_OFS_CTL, ctl(3'h0, 3'h2, 1'b0, 1'b0, 1'b1));
    wait_sel(3'h2, 20);
    wr(`TSS_OFS_CTL, ctl(3'h2, 3'h2, 1'b0, 1'b0, 1'b0) | 32'hc0);
    wr(`TSS_OFS_CTL, ctl(3'h2, 3'h0, 1'b0, 1'b0, 1'b1) | 32'hc0);
    rd_chk(`TSS_OFS_CTL, ctl(3'h2, 3'h0, 1'b0, 1'b0, 1'b0) | 32'hc0, 1'b0);
    chk({29'h0, core_clk_sel}, 32'h2, "locked selection held");

    // Source that never becomes ready
    boot(16'h00a2, 16'h0041, 16'd0, 16'd0, 16'd0);
    repeat (150) @(posedge pclk);
    chk({29'h0, core_clk_sel}, 32'h0, "still on fast RC");
    rd_chk(`TSS_OFS_CTL, ctl(3'h0, 3'h2, 1'b0, 1'b0, 1'b1), 1'b0);
    finish_test;
  end
endmodule
